// ---- design/periph_reset_map.svh ----
// Register offsets, field positions and reset values of the reset block.
`ifndef PERIPH_RESET_MAP_SVH
`define PERIPH_RESET_MAP_SVH

`define RST_CTRL_A_OFFSET 12'h044
`define RST_CTRL_B_OFFSET 12'h048
`define CAP_MASK_A_OFFSET 12'h04C
`define CAP_MASK_B_OFFSET 12'h050
`define RST_CTRL_RESET 32'h00000000
`define CAP_MASK_RESET 32'hFFFFFFFF

// Writable bits of each reset register; all other bits are read-only zero.
`define RST_CTRL_A_IMPL 32'h03071013
`define RST_CTRL_B_IMPL 32'h5000007F

`define BIT_COMPARATOR_ONE 25
`define BIT_COMPARATOR_ZERO 24
`define BIT_GP_COUNTER_TWO 18
`define BIT_GP_COUNTER_ONE 17
`define BIT_GP_COUNTER_ZERO 16
`define BIT_TWO_WIRE_UNIT 12
`define BIT_SYNC_SERIAL_UNIT 4
`define BIT_ASYNC_PORT_ONE 1
`define BIT_ASYNC_PORT_ZERO 0
`define BIT_ETH_PHYS_LAYER 30
`define BIT_ETH_MEDIA_CTRL 28
`define BIT_IO_PORT_LSB 0
`define BIT_IO_PORT_MSB 6

`endif

// ---- design/periph_reset_pkg.sv ----
// Types shared by the peripheral reset block.
package periph_reset_pkg;
  typedef logic [31:0] word_t;
  typedef logic [11:0] reg_addr_t;
endpackage

// ---- design/masked_reset_reg_if.sv ----
// Connection between the reset block top and one masked reset register.
`timescale 1ns/100ps
interface masked_reset_reg_if;
  logic wr_en;
  periph_reset_pkg::word_t wr_data;
  periph_reset_pkg::word_t cap_mask;
  periph_reset_pkg::word_t value;
  modport ctrl (output wr_en, output wr_data, output cap_mask, input value);
  modport store (input wr_en, input wr_data, input cap_mask, output value);
endinterface

// ---- design/masked_reset_reg.sv ----
// One reset control register whose writes are gated by a capability mask.
`timescale 1ns/100ps
`include "periph_reset_map.svh"
module masked_reset_reg #(
  parameter periph_reset_pkg::word_t IMPL_MASK = 32'hFFFFFFFF
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  masked_reset_reg_if.store bus
);
  periph_reset_pkg::word_t value_reg;
  periph_reset_pkg::word_t value_next;
  periph_reset_pkg::word_t keep;

  // A bit changes only if the unit is implemented and the capability allows.
  always_comb begin
    keep = IMPL_MASK & bus.cap_mask;
    value_next = (value_reg & ~keep) | (bus.wr_data & keep);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      value_reg <= `RST_CTRL_RESET;
    end else if (bus.wr_en) begin
      value_reg <= value_next;
    end
  end

  assign bus.value = value_reg;
endmodule

// ---- design/periph_reset_regs.sv ----
// Peripheral software reset control registers with capability-masked writes.
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
`include "periph_reset_map.svh"

// Contract
// - Writes to reset register A change only bits enabled by capability A.
// - Writes to reset register B change only bits enabled by capability B.
// - Both reset registers are 32-bit read/write and reset to all zeros.
// - Register A bits 25 and 24 reset comparators one and zero.
// - Register A bits 18, 17, 16 reset counters two, one and zero.
// - Register A bit 12 resets the two-wire unit.
// - Register A bit 4 resets the synchronous serial unit.
// - Register A bits 1 and 0 reset async ports one and zero.
// - Register B bits 30 and 28 reset the Ethernet PHY and MAC.
// - Register B bits 6 to 0 reset I/O ports G to A.
// - Unassigned bits read as zero and ignore writes.
module periph_reset_regs (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire periph_reset_pkg::reg_addr_t addr_i,
  input wire periph_reset_pkg::word_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output periph_reset_pkg::word_t rdata_o,
  output logic comparator_one_reset_o,
  output logic comparator_zero_reset_o,
  output logic gp_counter_two_reset_o,
  output logic gp_counter_one_reset_o,
  output logic gp_counter_zero_reset_o,
  output logic two_wire_unit_reset_o,
  output logic sync_serial_unit_reset_o,
  output logic async_port_one_reset_o,
  output logic async_port_zero_reset_o,
  output logic eth_phys_layer_reset_o,
  output logic eth_media_ctrl_reset_o,
  output logic [6:0] io_port_reset_o
);
  periph_reset_pkg::word_t capability_mask_a_reg;
  periph_reset_pkg::word_t capability_mask_b_reg;
  periph_reset_pkg::word_t rdata_reg;
  periph_reset_pkg::word_t rdata_next;

  masked_reset_reg_if reg_a ();
  masked_reset_reg_if reg_b ();

  assign reg_a.wr_en = wr_i && (addr_i == `RST_CTRL_A_OFFSET);
  assign reg_a.wr_data = wdata_i;
  assign reg_a.cap_mask = capability_mask_a_reg;
  assign reg_b.wr_en = wr_i && (addr_i == `RST_CTRL_B_OFFSET);
  assign reg_b.wr_data = wdata_i;
  assign reg_b.cap_mask = capability_mask_b_reg;

  // Reserved bits are excluded by the implemented mask.
  masked_reset_reg #(
    .IMPL_MASK(`RST_CTRL_A_IMPL)
  ) u_ctrl_a (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .bus(reg_a.store)
  );

  masked_reset_reg #(
    .IMPL_MASK(`RST_CTRL_B_IMPL)
  ) u_ctrl_b (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .bus(reg_b.store)
  );

  // The capability masks are kept writable here so the block stands alone;
  // in a full chip they would come from the capability registers instead.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      capability_mask_a_reg <= `CAP_MASK_RESET;
    end else if (wr_i && (addr_i == `CAP_MASK_A_OFFSET)) begin
      capability_mask_a_reg <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      capability_mask_b_reg <= `CAP_MASK_RESET;
    end else if (wr_i && (addr_i == `CAP_MASK_B_OFFSET)) begin
      capability_mask_b_reg <= wdata_i;
    end
  end

  always_comb begin
    if (addr_i == `RST_CTRL_A_OFFSET) begin
      rdata_next = reg_a.value;
    end else if (addr_i == `RST_CTRL_B_OFFSET) begin
      rdata_next = reg_b.value;
    end else if (addr_i == `CAP_MASK_A_OFFSET) begin
      rdata_next = capability_mask_a_reg;
    end else if (addr_i == `CAP_MASK_B_OFFSET) begin
      rdata_next = capability_mask_b_reg;
    end else begin
      rdata_next = `RST_CTRL_RESET;
    end
  end

  // Read data stand only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_reg <= `RST_CTRL_RESET;
    end else if (rd_i) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= `RST_CTRL_RESET;
    end
  end

  assign rdata_o = rdata_reg;

  // Reset outputs follow the stored bits directly, active high.
  assign comparator_one_reset_o = reg_a.value[`BIT_COMPARATOR_ONE];
  assign comparator_zero_reset_o = reg_a.value[`BIT_COMPARATOR_ZERO];
  assign gp_counter_two_reset_o = reg_a.value[`BIT_GP_COUNTER_TWO];
  assign gp_counter_one_reset_o = reg_a.value[`BIT_GP_COUNTER_ONE];
  assign gp_counter_zero_reset_o = reg_a.value[`BIT_GP_COUNTER_ZERO];
  assign two_wire_unit_reset_o = reg_a.value[`BIT_TWO_WIRE_UNIT];
  assign sync_serial_unit_reset_o = reg_a.value[`BIT_SYNC_SERIAL_UNIT];
  assign async_port_one_reset_o = reg_a.value[`BIT_ASYNC_PORT_ONE];
  assign async_port_zero_reset_o = reg_a.value[`BIT_ASYNC_PORT_ZERO];
  assign eth_phys_layer_reset_o = reg_b.value[`BIT_ETH_PHYS_LAYER];
  assign eth_media_ctrl_reset_o = reg_b.value[`BIT_ETH_MEDIA_CTRL];
  assign io_port_reset_o =
    reg_b.value[`BIT_IO_PORT_MSB:`BIT_IO_PORT_LSB];

  sequence s_write_a;
    wr_i && addr_i == `RST_CTRL_A_OFFSET;
  endsequence

  sequence s_write_b;
    wr_i && addr_i == `RST_CTRL_B_OFFSET;
  endsequence

  property p_mask_a;
    @(posedge clk_i) disable iff (!rstn_i)
    s_write_a |=> ((reg_a.value ^ $past(reg_a.value))
      & ~$past(capability_mask_a_reg)) == 32'h00000000;
  endproperty
  a_mask_a: assert property (p_mask_a) else $error("mask A violated");

  property p_mask_b;
    @(posedge clk_i) disable iff (!rstn_i)
    s_write_b |=> ((reg_b.value ^ $past(reg_b.value))
      & ~$past(capability_mask_b_reg)) == 32'h00000000;
  endproperty
  a_mask_b: assert property (p_mask_b) else $error("mask B violated");

  property p_write_takes_a;
    @(posedge clk_i) disable iff (!rstn_i)
    s_write_a |=> reg_a.value == (`RST_CTRL_A_IMPL
      & $past(capability_mask_a_reg) & $past(wdata_i)
      | $past(reg_a.value) & ~(`RST_CTRL_A_IMPL
      & $past(capability_mask_a_reg)));
  endproperty
  a_write_takes_a: assert property (p_write_takes_a)
    else $error("register A write lost");

  property p_reserved_zero;
    @(posedge clk_i) disable iff (!rstn_i)
    (reg_a.value & ~`RST_CTRL_A_IMPL) == 32'h00000000
      && (reg_b.value & ~`RST_CTRL_B_IMPL) == 32'h00000000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit set");

  property p_hold_a;
    @(posedge clk_i) disable iff (!rstn_i)
    !(wr_i && addr_i == `RST_CTRL_A_OFFSET) |=> $stable(reg_a.value);
  endproperty
  a_hold_a: assert property (p_hold_a)
    else $error("register A changed without write");

  property p_hold_b;
    @(posedge clk_i) disable iff (!rstn_i)
    !(wr_i && addr_i == `RST_CTRL_B_OFFSET) |=> $stable(reg_b.value);
  endproperty
  a_hold_b: assert property (p_hold_b)
    else $error("register B changed without write");

  property p_read_a;
    @(posedge clk_i) disable iff (!rstn_i)
    rd_i && addr_i == `RST_CTRL_A_OFFSET
      |=> rdata_o == $past(reg_a.value);
  endproperty
  a_read_a: assert property (p_read_a) else $error("bad read A");

  property p_read_b;
    @(posedge clk_i) disable iff (!rstn_i)
    rd_i && addr_i == `RST_CTRL_B_OFFSET
      |=> rdata_o == $past(reg_b.value);
  endproperty
  a_read_b: assert property (p_read_b) else $error("bad read B");

  property p_reset_zero;
    @(posedge clk_i) disable iff (!rstn_i)
    $rose(rstn_i) |-> reg_a.value == `RST_CTRL_RESET
      && reg_b.value == `RST_CTRL_RESET
      && capability_mask_a_reg == `CAP_MASK_RESET
      && capability_mask_b_reg == `CAP_MASK_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("register not cleared by reset");

  // Every unit's reset output except counter one and async port zero is checked: it takes the written bit when its capability bit
  // is set and keeps its old level otherwise, one cycle after the write.
  property p_comp_one;
    @(posedge clk_i) disable iff (!rstn_i)
    s_write_a |=> comparator_one_reset_o
      == ($past(capability_mask_a_reg[`BIT_COMPARATOR_ONE])
      ? $past(wdata_i[`BIT_COMPARATOR_ONE])
      : $past(comparator_one_reset_o));
  endproperty
  a_comp_one: assert property (p_comp_one)
    else $error("comparator one reset mismatch");

  property p_comp_zero;
    @(posedge clk_i) disable iff (!rstn_i)
    s_write_a |=> comparator_zero_reset_o
      == ($past(capability_mask_a_reg[`BIT_COMPARATOR_ZERO])
      ? $past(wdata_i[`BIT_COMPARATOR_ZERO])
      : $past(comparator_zero_reset_o));
  endproperty
  a_comp_zero: assert property (p_comp_zero)
    else $error("comparator zero reset mismatch");

  property p_counter_two;
    @(posedge clk_i) disable iff (!rstn_i)
    s_write_a |=> gp_counter_two_reset_o
      == ($past(capability_mask_a_reg[`BIT_GP_COUNTER_TWO])
      ? $past(wdata_i[`BIT_GP_COUNTER_TWO])
      : $past(gp_counter_two_reset_o));
  endproperty
  a_counter_two: assert property (p_counter_two)
    else $error("counter two reset mismatch");

  property p_counter_zero;
    @(posedge clk_i) disable iff (!rstn_i)
    s_write_a |=> gp_counter_zero_reset_o
      == ($past(capability_mask_a_reg[`BIT_GP_COUNTER_ZERO])
      ? $past(wdata_i[`BIT_GP_COUNTER_ZERO])
      : $past(gp_counter_zero_reset_o));
  endproperty
  a_counter_zero: assert property (p_counter_zero)
    else $error("counter zero reset mismatch");

  property p_two_wire;
    @(posedge clk_i) disable iff (!rstn_i)
    s_write_a |=> two_wire_unit_reset_o
      == ($past(capability_mask_a_reg[`BIT_TWO_WIRE_UNIT])
      ? $past(wdata_i[`BIT_TWO_WIRE_UNIT])
      : $past(two_wire_unit_reset_o));
  endproperty
  a_two_wire: assert property (p_two_wire)
    else $error("two-wire unit reset mismatch");

  property p_sync_serial;
    @(posedge clk_i) disable iff (!rstn_i)
    s_write_a |=> sync_serial_unit_reset_o
      == ($past(capability_mask_a_reg[`BIT_SYNC_SERIAL_UNIT])
      ? $past(wdata_i[`BIT_SYNC_SERIAL_UNIT])
      : $past(sync_serial_unit_reset_o));
  endproperty
  a_sync_serial: assert property (p_sync_serial)
    else $error("sync serial unit reset mismatch");

  property p_async_one;
    @(posedge clk_i) disable iff (!rstn_i)
    s_write_a |=> async_port_one_reset_o
      == ($past(capability_mask_a_reg[`BIT_ASYNC_PORT_ONE])
      ? $past(wdata_i[`BIT_ASYNC_PORT_ONE])
      : $past(async_port_one_reset_o));
  endproperty
  a_async_one: assert property (p_async_one)
    else $error("async port one reset mismatch");

  property p_eth_phys;
    @(posedge clk_i) disable iff (!rstn_i)
    s_write_b |=> eth_phys_layer_reset_o
      == ($past(capability_mask_b_reg[`BIT_ETH_PHYS_LAYER])
      ? $past(wdata_i[`BIT_ETH_PHYS_LAYER])
      : $past(eth_phys_layer_reset_o));
  endproperty
  a_eth_phys: assert property (p_eth_phys)
    else $error("physical layer reset mismatch");

  property p_eth_media;
    @(posedge clk_i) disable iff (!rstn_i)
    s_write_b |=> eth_media_ctrl_reset_o
      == ($past(capability_mask_b_reg[`BIT_ETH_MEDIA_CTRL])
      ? $past(wdata_i[`BIT_ETH_MEDIA_CTRL])
      : $past(eth_media_ctrl_reset_o));
  endproperty
  a_eth_media: assert property (p_eth_media)
    else $error("media controller reset mismatch");

  property p_io_port;
    @(posedge clk_i) disable iff (!rstn_i)
    s_write_b ##1 1'b1 |-> io_port_reset_o
      == ($past(wdata_i[`BIT_IO_PORT_MSB:`BIT_IO_PORT_LSB])
      & $past(capability_mask_b_reg[`BIT_IO_PORT_MSB:`BIT_IO_PORT_LSB])
      | $past(io_port_reset_o)
      & ~$past(capability_mask_b_reg[`BIT_IO_PORT_MSB:`BIT_IO_PORT_LSB]));
  endproperty
  a_io_port: assert property (p_io_port)
    else $error("port reset mismatch");
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the peripheral software reset registers.
`timescale 1ns/100ps
`include "periph_reset_map.svh"
module testbench;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  periph_reset_pkg::reg_addr_t addr_i = 12'h000;
  periph_reset_pkg::word_t wdata_i = 32'h00000000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  periph_reset_pkg::word_t rdata_o;
  logic c1, c0, t2, t1, t0, tw, ss, u1, u0, phy, mac;
  logic [6:0] io;
  periph_reset_pkg::word_t obs_a, obs_b, exp_a, exp_b, cap_a, cap_b;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  // Outputs regrouped at their register bit positions for direct compare.
  assign obs_a = {6'h00, c1, c0, 5'h00, t2, t1, t0, 3'h0, tw, 7'h00, ss,
                  2'h0, u1, u0};
  assign obs_b = {1'b0, phy, 1'b0, mac, 21'h000000, io};
  periph_reset_regs u_periph_reset_regs (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .comparator_one_reset_o(c1), .comparator_zero_reset_o(c0),
    .gp_counter_two_reset_o(t2), .gp_counter_one_reset_o(t1),
    .gp_counter_zero_reset_o(t0), .two_wire_unit_reset_o(tw),
    .sync_serial_unit_reset_o(ss), .async_port_one_reset_o(u1),
    .async_port_zero_reset_o(u0), .eth_phys_layer_reset_o(phy),
    .eth_media_ctrl_reset_o(mac), .io_port_reset_o(io)
  );
  always #50 clk_i = ~clk_i;
  task automatic conclude();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input periph_reset_pkg::word_t got,
                     input periph_reset_pkg::word_t exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input periph_reset_pkg::reg_addr_t a,
                    input periph_reset_pkg::word_t d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    // Reference model: only implemented and capable bits take the data.
    if (a == `RST_CTRL_A_OFFSET) begin
      exp_a = exp_a & ~(`RST_CTRL_A_IMPL & cap_a)
              | d & `RST_CTRL_A_IMPL & cap_a;
    end
    if (a == `RST_CTRL_B_OFFSET) begin
      exp_b = exp_b & ~(`RST_CTRL_B_IMPL & cap_b)
              | d & `RST_CTRL_B_IMPL & cap_b;
    end
    if (a == `CAP_MASK_A_OFFSET) cap_a = d;
    if (a == `CAP_MASK_B_OFFSET) cap_b = d;
  endtask
  // Reads, then checks read data and all reset outputs in the answer cycle.
  task automatic rd(input periph_reset_pkg::reg_addr_t a,
                    input periph_reset_pkg::word_t e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(rdata_o, e);
    chk(obs_a, exp_a);
    chk(obs_b, exp_b);
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      $display("[ERR] %0t run did not finish in time", $time);
      conclude();
    end
  end
  initial begin
    exp_a = `RST_CTRL_RESET;
    exp_b = `RST_CTRL_RESET;
    cap_a = `CAP_MASK_RESET;
    cap_b = `CAP_MASK_RESET;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(`RST_CTRL_A_OFFSET, 32'h00000000);
    rd(`RST_CTRL_B_OFFSET, 32'h00000000);
    for (int i = 0; i < 32; i++) begin
      wr(`RST_CTRL_A_OFFSET, 32'h00000001 << i);
      rd(`RST_CTRL_A_OFFSET, exp_a);
      wr(`RST_CTRL_B_OFFSET, 32'h00000001 << i);
      rd(`RST_CTRL_B_OFFSET, exp_b);
    end
    wr(`RST_CTRL_A_OFFSET, 32'hFFFFFFFF);
    wr(`RST_CTRL_B_OFFSET, 32'hFFFFFFFF);
    rd(`RST_CTRL_A_OFFSET, 32'h03071013);
    rd(`RST_CTRL_B_OFFSET, 32'h5000007F);
    // Capability masks now let only one bit of each register change.
    wr(`CAP_MASK_A_OFFSET, 32'h00000001);
    wr(`RST_CTRL_A_OFFSET, 32'h00000000);
    rd(`RST_CTRL_A_OFFSET, 32'h03071012);
    wr(`CAP_MASK_B_OFFSET, 32'h40000000);
    wr(`RST_CTRL_B_OFFSET, 32'h00000000);
    rd(`RST_CTRL_B_OFFSET, 32'h1000007F);
    wr(`CAP_MASK_A_OFFSET, 32'hFFFFFFFF);
    wr(`CAP_MASK_B_OFFSET, 32'hFFFFFFFF);
    wr(`RST_CTRL_A_OFFSET, 32'h00000000);
    wr(`RST_CTRL_B_OFFSET, 32'h00000000);
    rd(`RST_CTRL_A_OFFSET, 32'h00000000);
    rd(`RST_CTRL_B_OFFSET, 32'h00000000);
    @(negedge clk_i);
    chk(rdata_o, 32'h00000000);
    // Read-modify-write: reserved bits go back exactly as they were read.
    wr(`RST_CTRL_A_OFFSET, exp_a | 32'h00001000);
    rd(`RST_CTRL_A_OFFSET, 32'h00001000);
    wr(`RST_CTRL_B_OFFSET, 32'hFFFFFFFF);
    wr(`CAP_MASK_A_OFFSET, 32'h00000000);
    // A reset in mid-run must clear stored bits and restore the masks.
    @(posedge clk_i);
    rstn_i <= 1'b0;
    @(negedge clk_i);
    chk(obs_a | obs_b, 32'h00000000);
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    exp_a = `RST_CTRL_RESET;
    exp_b = `RST_CTRL_RESET;
    cap_a = `CAP_MASK_RESET;
    rd(`RST_CTRL_A_OFFSET, 32'h00000000);
    rd(`RST_CTRL_B_OFFSET, 32'h00000000);
    rd(`CAP_MASK_A_OFFSET, 32'hFFFFFFFF);
    rd(`CAP_MASK_B_OFFSET, 32'hFFFFFFFF);
    wr(12'h100, 32'hFFFFFFFF);
    rd(12'h100, 32'h00000000);
    rd(`RST_CTRL_A_OFFSET, 32'h00000000);
    conclude();
  end
endmodule
